/* dcc_config.v */
// configuration registers and controlled logic of the deserializer control channel
//
// Functional notes
// - back-channel crc generation follows config bit 6; resets enabled.
// - sync filter bit 4 rejects hs, vs, de pulses under two pixel clocks.
// - alias pass bit 3 forwards alias-matched local transactions to remote; off at reset.
// - auto-ack bit 2 acknowledges transactions regardless of forward lock; off at reset.
// - gating bit 1 gates rgb with de in compatibility mode; off at reset.
// - watchdog ends unfinished channel transaction after timeout field times 2 ms.
// - watchdog runs while timeout-off bit 0 is clear; reset clear.
// - pass-all bit 7 forwards every local transaction; off at reset.
// - incoming sda delayed by hold field times 50 ns.
// - scl and sda glitches up to depth field times 5 ns rejected.
`default_nettype none
`include "dcc_map.vh"
module dcc_config #(
  parameter WD_UNIT_CYCLES = `DCC_WD_UNIT_US * `DCC_CLK_MHZ,
  parameter RGB_W = 24
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // register port of the serial control bus
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // pixel pins
  input wire pclk_pin,
  input wire hs_pin,
  input wire vs_pin,
  input wire de_pin,
  input wire [RGB_W-1:0] rgb_pin,
  input wire compat_mode,
  output reg hs_out,
  output reg vs_out,
  output reg de_out,
  output reg [RGB_W-1:0] rgb_out,
  output reg crc_gen_en,
  // serial bus pins
  input wire scl_pin,
  input wire sda_pin,
  output reg scl_filt,
  output reg sda_filt,
  // local target transactions
  input wire txn_start,
  input wire alias_hit,
  input wire fwd_lock,
  input wire fwd_done,
  output reg txn_ack_en,
  output reg fwd_busy,
  output reg fwd_abort
);
  localparam ST_IDLE = 2'b01;
  localparam ST_FWD = 2'b10;
  localparam HOLD_CYC = `DCC_HOLD_UNIT_NS / `DCC_CLK_NS;
  localparam HOLD_LEN = 7 * HOLD_CYC;
  localparam [2:0] SYNC_THR_ON = `DCC_SYNC_FILT_EDGES;
  // ****************************************
  // registers
  // ****************************************
  reg [7:0] general_config_one;
  reg [7:0] control_channel_watchdog_ctrl;
  reg [7:0] serial_bus_control_one;
  wire [6:0] channel_timeout_value = control_channel_watchdog_ctrl[`DCC_TIMEOUT_MSB:`DCC_TIMEOUT_LSB];
  wire channel_timeout_off = control_channel_watchdog_ctrl[`DCC_BIT_TIMEOUT_OFF];
  wire pixel_gating_by_data_enable = general_config_one[`DCC_BIT_GATE_RGB];
  wire [2:0] hold_sel = serial_bus_control_one[`DCC_HOLD_MSB:`DCC_HOLD_LSB];
  wire [3:0] depth = serial_bus_control_one[`DCC_DEPTH_MSB:`DCC_DEPTH_LSB];
  always @(posedge core_clk) begin
    if (!nrst) begin
      general_config_one <= `DCC_RST_GEN_CFG_ONE;
      control_channel_watchdog_ctrl <= `DCC_RST_WD_CTRL;
      serial_bus_control_one <= `DCC_RST_SBUS_CTRL_ONE;
    end else if (reg_wr) begin
      case (reg_addr)
        `DCC_ADDR_GEN_CFG_ONE: begin
          // reserved bits keep their reset value
          general_config_one <= {1'b1, reg_wdata[6:1], 1'b0};
        end
        `DCC_ADDR_WD_CTRL: begin
          control_channel_watchdog_ctrl <= reg_wdata;
        end
        `DCC_ADDR_SBUS_CTRL_ONE: begin
          serial_bus_control_one <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end
  always @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `DCC_ADDR_GEN_CFG_ONE: reg_rdata <= general_config_one;
        `DCC_ADDR_WD_CTRL: reg_rdata <= control_channel_watchdog_ctrl;
        `DCC_ADDR_SBUS_CTRL_ONE: reg_rdata <= serial_bus_control_one;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam SW = RGB_W + 6;
  reg [SW-1:0] sync1;
  reg [SW-1:0] sync2;
  always @(posedge core_clk) begin
    if (!nrst) begin
      // serial bus lines rest high so no false edge follows reset
      sync1 <= {{RGB_W{1'b0}}, 6'h30};
      sync2 <= {{RGB_W{1'b0}}, 6'h30};
    end else begin
      sync1 <= {rgb_pin, sda_pin, scl_pin, de_pin, vs_pin, hs_pin, pclk_pin};
      sync2 <= sync1;
    end
  end
  reg pclk_d;
  always @(posedge core_clk) begin
    if (!nrst) begin
      pclk_d <= 1'b0;
    end else begin
      pclk_d <= sync2[0];
    end
  end
  wire pclk_rise = sync2[0] & ~pclk_d;
  // ****************************************
  // sync filter and rgb gating
  // ****************************************
  wire [2:0] sync_filt;
  wire [2:0] sync_thr = general_config_one[`DCC_BIT_SYNC_FILT] ?
    SYNC_THR_ON : 3'd1;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      dcc_filter #(.CW(3)) u_filt (
        .core_clk(core_clk),
        .nrst(nrst),
        .sample_en(pclk_rise),
        .din(sync2[gi+1]),
        .thr(sync_thr),
        .rst_val(1'b0),
        .dout(sync_filt[gi])
      );
    end
  endgenerate
  reg [RGB_W-1:0] rgb_cap;
  always @(posedge core_clk) begin
    if (!nrst) begin
      rgb_cap <= {RGB_W{1'b0}};
      hs_out <= 1'b0;
      vs_out <= 1'b0;
      de_out <= 1'b0;
      rgb_out <= {RGB_W{1'b0}};
      crc_gen_en <= 1'b1;
    end else begin
      if (pclk_rise) begin
        rgb_cap <= sync2[SW-1:6];
      end
      hs_out <= sync_filt[0];
      vs_out <= sync_filt[1];
      de_out <= sync_filt[2];
      if (pixel_gating_by_data_enable && compat_mode && !sync_filt[2]) begin
        rgb_out <= {RGB_W{1'b0}};
      end else begin
        rgb_out <= rgb_cap;
      end
      crc_gen_en <= general_config_one[`DCC_BIT_CRC_EN];
    end
  end
  // ****************************************
  // serial bus glitch filter and sda hold
  // ****************************************
  // 7 bits hold the widest depth of 75 ns
  localparam [6:0] GLITCH_UNIT = `DCC_GLITCH_UNIT_NS;
  localparam [6:0] CLK_PERIOD = `DCC_CLK_NS;
  wire [6:0] glitch_ns = {3'h0, depth} * GLITCH_UNIT;
  wire [6:0] glitch_cyc = (glitch_ns + CLK_PERIOD - 7'h01) / CLK_PERIOD;
  wire [4:0] glitch_thr = {2'h0, glitch_cyc[2:0]} + 5'h01;
  wire [1:0] bus_filt;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_bus
      dcc_filter #(.CW(5)) u_filt (
        .core_clk(core_clk),
        .nrst(nrst),
        .sample_en(1'b1),
        .din(sync2[gi+4]),
        .thr(glitch_thr),
        .rst_val(1'b1),
        .dout(bus_filt[gi])
      );
    end
  endgenerate
  reg [HOLD_LEN-1:0] sda_line;
  // tap 0 is the undelayed line, so a zero hold adds no skew to scl
  wire [HOLD_LEN:0] sda_taps = {sda_line, bus_filt[1]};
  always @(posedge core_clk) begin
    if (!nrst) begin
      sda_line <= {HOLD_LEN{1'b1}};
      scl_filt <= 1'b1;
      sda_filt <= 1'b1;
    end else begin
      sda_line <= {sda_line[HOLD_LEN-2:0], bus_filt[1]};
      scl_filt <= bus_filt[0];
      sda_filt <= sda_taps[hold_sel * HOLD_CYC];
    end
  end
  // ****************************************
  // forwarding and watchdog
  // ****************************************
  reg [1:0] state;
  reg [16:0] unit_cnt;
  reg [6:0] units;
  wire fwd_take = general_config_one[`DCC_BIT_ALIAS_PASS] && alias_hit;
  wire fwd_any = serial_bus_control_one[`DCC_BIT_PASS_ALL] || fwd_take;
  wire unit_end = (unit_cnt == WD_UNIT_CYCLES - 1);
  wire expire = !channel_timeout_off && unit_end &&
    (units + 7'd1 >= channel_timeout_value);
  always @(posedge core_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      unit_cnt <= 17'h0_0000;
      units <= 7'h00;
      fwd_busy <= 1'b0;
      fwd_abort <= 1'b0;
      txn_ack_en <= 1'b0;
    end else begin
      txn_ack_en <= fwd_lock || general_config_one[`DCC_BIT_AUTO_ACK];
      fwd_abort <= 1'b0;
      case (state)
        ST_IDLE: begin
          unit_cnt <= 17'h0_0000;
          units <= 7'h00;
          if (txn_start && fwd_any) begin
            state <= ST_FWD;
            fwd_busy <= 1'b1;
          end
        end
        ST_FWD: begin
          if (fwd_done) begin
            state <= ST_IDLE;
            fwd_busy <= 1'b0;
          end else if (expire) begin
            state <= ST_IDLE;
            fwd_busy <= 1'b0;
            fwd_abort <= 1'b1;
          end else if (!channel_timeout_off) begin
            if (unit_end) begin
              unit_cnt <= 17'h0_0000;
              units <= units + 7'd1;
            end else begin
              unit_cnt <= unit_cnt + 17'd1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          fwd_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // dcc_config
`default_nettype wire

/* dcc_map.vh */
// register map and timing constants of the deserializer control channel config block
`ifndef DCC_MAP_VH
`define DCC_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define DCC_ADDR_GEN_CFG_ONE 8'h03
`define DCC_ADDR_WD_CTRL 8'h04
`define DCC_ADDR_SBUS_CTRL_ONE 8'h05
// ****************************************
// reset values
// ****************************************
`define DCC_RST_GEN_CFG_ONE 8'hf0
`define DCC_RST_WD_CTRL 8'hfe
`define DCC_RST_SBUS_CTRL_ONE 8'h1e
// ****************************************
// field positions
// ****************************************
`define DCC_BIT_RSVD_HI 7
`define DCC_BIT_CRC_EN 6
`define DCC_BIT_FAILSAFE 5
`define DCC_BIT_SYNC_FILT 4
`define DCC_BIT_ALIAS_PASS 3
`define DCC_BIT_AUTO_ACK 2
`define DCC_BIT_GATE_RGB 1
`define DCC_BIT_TIMEOUT_OFF 0
`define DCC_BIT_PASS_ALL 7
`define DCC_TIMEOUT_MSB 7
`define DCC_TIMEOUT_LSB 1
`define DCC_HOLD_MSB 6
`define DCC_HOLD_LSB 4
`define DCC_DEPTH_MSB 3
`define DCC_DEPTH_LSB 0
// ****************************************
// timing
// ****************************************
`define DCC_CLK_NS 25
`define DCC_CLK_MHZ 40
`define DCC_WD_UNIT_US 2000
`define DCC_HOLD_UNIT_NS 50
`define DCC_GLITCH_UNIT_NS 5
`define DCC_SYNC_FILT_EDGES 2
`endif

/* dcc_filter.v */
// one-bit filter that accepts a new level only after it persists for a set number of samples
`default_nettype none
module dcc_filter #(
  parameter CW = 5
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // sample
  input wire sample_en,
  input wire din,
  input wire [CW-1:0] thr,
  input wire rst_val,
  // filtered level
  output reg dout
);
  reg [CW-1:0] cnt;
  always @(posedge core_clk) begin
    if (!nrst) begin
      cnt <= {CW{1'b0}};
      dout <= rst_val;
    end else if (din == dout) begin
      cnt <= {CW{1'b0}};
    end else if (sample_en) begin
      if (cnt + 1'b1 >= thr) begin
        dout <= din;
        cnt <= {CW{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule // dcc_filter
`default_nettype wire

/* dcc_config_asserts.sv */
// assertion checker of the control channel config block
`default_nettype none
module dcc_config_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // channel control
  input wire logic crc_gen_en,
  input wire logic txn_start,
  input wire logic fwd_lock,
  input wire logic fwd_done,
  input wire logic txn_ack_en,
  input wire logic fwd_busy,
  input wire logic fwd_abort
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  crc_mirror_a: assert property (
    reg_wr && reg_addr == 8'h03 ##1 !reg_wr [*2] |-> crc_gen_en == $past(reg_wdata[6], 2))
    else $error("crc enable mismatch");
  lock_ack_a: assert property (fwd_lock |=> txn_ack_en)
    else $error("ack missing while locked");
  done_idle_a: assert property (fwd_busy && fwd_done |=> !fwd_busy)
    else $error("busy after done");
  abort_pulse_a: assert property (fwd_abort |=> !fwd_abort)
    else $error("abort too long");
  abort_cause_a: assert property (fwd_abort |-> $past(fwd_busy))
    else $error("abort without busy");
  busy_cause_a: assert property ($rose(fwd_busy) |-> $past(txn_start))
    else $error("busy without start");
  reg_read_a: assert property (
    reg_wr && reg_addr == 8'h04 ##1 !reg_wr && reg_addr == 8'h04
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
  unmapped_a: assert property (
    (reg_addr > 8'h05 || reg_addr < 8'h03) && $stable(reg_addr) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // dcc_config_asserts
`default_nettype wire

/* dcc_remote_model.sv */
// remote serializer model answering forwarded transactions
`default_nettype none
module dcc_remote_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // forward handshake
  input wire logic fwd_busy,
  input wire logic hang,
  output var logic fwd_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  // answers some cycles after a forward starts, never while hanging
  always @(posedge core_clk) begin
    fwd_done <= 1'b0;
    if (!nrst || !fwd_busy || fwd_done) begin
      cnt <= 4'h0;
    end else if (!hang) begin
      cnt <= cnt + 4'h1;
      fwd_done <= (cnt == 4'h5);
    end
  end
endmodule // dcc_remote_model
`default_nettype wire

/* deser_control_channel_config_bench.sv */
// self-checking bench of the control channel config block
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module deser_control_channel_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic pclk_pin = 1'b0;
  logic hs_pin = 1'b0;
  logic vs_pin = 1'b0;
  logic de_pin = 1'b0;
  logic [23:0] rgb_pin = 24'h12_3456;
  logic compat_mode = 1'b1;
  logic scl_pin = 1'b1;
  logic sda_pin = 1'b1;
  logic txn_start = 1'b0;
  logic alias_hit = 1'b0;
  logic fwd_lock = 1'b0;
  logic hang = 1'b0;
  logic fwd_done;
  logic [7:0] reg_rdata;
  logic [23:0] rgb_out;
  logic hs_out, vs_out, de_out, crc_gen_en, scl_filt, sda_filt;
  logic txn_ack_en, fwd_busy, fwd_abort;
  logic [2:0] s;
  int total_checks = 0;
  int n_mismatch = 0;
  int n;
  int h;
  always #12.5 core_clk = ~core_clk;
  initial begin
    #37;
    forever #100 pclk_pin = ~pclk_pin;
  end
  dcc_config #(.WD_UNIT_CYCLES(20)) i_dut (.core_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .pclk_pin, .hs_pin, .vs_pin, .de_pin, .rgb_pin, .compat_mode, .hs_out,
    .vs_out, .de_out, .rgb_out, .crc_gen_en, .scl_pin, .sda_pin, .scl_filt, .sda_filt,
    .txn_start, .alias_hit, .fwd_lock, .fwd_done, .txn_ack_en, .fwd_busy, .fwd_abort);
  dcc_remote_model i_remote (.core_clk, .nrst, .fwd_busy, .hang, .fwd_done);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    repeat (2) @(negedge core_clk);
    `CHK(reg_rdata, e)
  endtask
  task automatic start(input logic h);
    @(negedge core_clk);
    txn_start = 1'b1;
    alias_hit = h;
    @(negedge core_clk);
    txn_start = 1'b0;
  endtask
  task automatic idle;
    for (n = 0; n < 60 && fwd_busy !== 1'b0; n++) @(negedge core_clk);
  endtask
  task automatic pulse;
    s = 3'b000;
    @(negedge core_clk);
    hs_pin = 1'b1;
    vs_pin = 1'b1;
    de_pin = 1'b1;
    repeat (8) @(negedge core_clk);
    hs_pin = 1'b0;
    vs_pin = 1'b0;
    de_pin = 1'b0;
    repeat (30) begin
      @(negedge core_clk);
      s |= {de_out, vs_out, hs_out};
    end
  endtask
  task automatic bus_low(input int k);
    s = 3'b000;
    for (n = 0; n < 24; n++) begin
      @(negedge core_clk);
      scl_pin = (n >= k);
      sda_pin = (n >= k);
      s[1:0] |= {~sda_filt, ~scl_filt};
    end
  endtask
  task automatic t_regs;
    rc(8'h03, 8'hf0);
    rc(8'h04, 8'hfe);
    rc(8'h05, 8'h1e);
    `CHK(crc_gen_en, 1'b1)
    wr(8'h03, 8'h01);
    rc(8'h03, 8'h80);
    `CHK(crc_gen_en, 1'b0)
    wr(8'h05, 8'h7f);
    rc(8'h05, 8'h7f);
    wr(8'h06, 8'hff);
    rc(8'h06, 8'h00);
    $display("test regs end");
  endtask
  task automatic t_fwd;
    wr(8'h05, 8'h9e);
    start(1'b0);
    `CHK(fwd_busy, 1'b1)
    idle;
    `CHK(fwd_busy, 1'b0)
    wr(8'h05, 8'h1e);
    wr(8'h03, 8'hf8);
    start(1'b0);
    `CHK(fwd_busy, 1'b0)
    start(1'b1);
    `CHK(fwd_busy, 1'b1)
    idle;
    $display("test fwd end");
  endtask
  task automatic t_wd;
    hang = 1'b1;
    wr(8'h04, 8'h04);
    start(1'b1);
    for (n = 0; n < 200 && fwd_abort !== 1'b1; n++) @(negedge core_clk);
    `CHK(n >= 38 && n <= 44, 1'b1)
    `CHK(fwd_busy, 1'b0)
    wr(8'h04, 8'h05);
    start(1'b1);
    `CHK(fwd_busy, 1'b1)
    repeat (100) @(negedge core_clk);
    `CHK(fwd_busy, 1'b1)
    hang = 1'b0;
    idle;
    $display("test watchdog end");
  endtask
  task automatic t_pix;
    wr(8'h03, 8'hf2);
    fwd_lock = 1'b1;
    repeat (40) @(negedge core_clk);
    `CHK(txn_ack_en, 1'b1)
    fwd_lock = 1'b0;
    `CHK(rgb_out, 24'h00_0000)
    compat_mode = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(txn_ack_en, 1'b0)
    `CHK(rgb_out, 24'h12_3456)
    compat_mode = 1'b1;
    wr(8'h03, 8'hf4);
    repeat (40) @(negedge core_clk);
    `CHK(rgb_out, 24'h12_3456)
    `CHK(txn_ack_en, 1'b1)
    pulse;
    `CHK(s, 3'b000)
    wr(8'h03, 8'he0);
    pulse;
    `CHK(s, 3'b111)
    $display("test pixel end");
  endtask
  task automatic t_bus;
    wr(8'h05, 8'h2a);
    repeat (4) @(negedge core_clk);
    bus_low(2);
    `CHK(s[1:0], 2'b00)
    bus_low(4);
    `CHK(s[1:0], 2'b11)
    repeat (10) @(negedge core_clk);
    h = 0;
    scl_pin = 1'b0;
    sda_pin = 1'b0;
    repeat (30) begin
      @(negedge core_clk);
      if (scl_filt === 1'b0 && sda_filt === 1'b1) h++;
    end
    scl_pin = 1'b1;
    sda_pin = 1'b1;
    repeat (30) @(negedge core_clk);
    `CHK(h, 4)
    $display("test bus end");
  endtask
  task automatic t_rst;
    wr(8'h04, 8'h10);
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK({scl_filt, sda_filt, crc_gen_en, fwd_busy}, 4'b1110)
    rc(8'h04, 8'hfe);
    rc(8'h05, 8'h1e);
    $display("test reset end");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_mismatch++;
    results;
  end
  initial begin
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    t_regs;
    t_fwd;
    t_wd;
    t_pix;
    t_bus;
    t_rst;
    results;
  end
endmodule // deser_control_channel_config_bench
bind dcc_config dcc_config_asserts u_chk (.core_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata,
  .reg_rdata, .crc_gen_en, .txn_start, .fwd_lock, .fwd_done, .txn_ack_en, .fwd_busy,
  .fwd_abort);
`default_nettype wire
